// ===== rtl/fslc_defs.svh
// Constants for the sector lock command block: opcodes, frame lengths and timing.
// Assumes a host that frames each command with chip select and a serial clock.
`ifndef FSLC_DEFS_SVH
`define FSLC_DEFS_SVH

`define FSLC_OP_UNLOCK     8'h39
`define FSLC_OP_UNLOCK4    8'hE2
`define FSLC_OP_GLOCK      8'h7E
`define FSLC_OP_GUNLOCK    8'h98
`define FSLC_OP_PTR        8'hFB
`define FSLC_OP_PTR4       8'hE3
`define FSLC_OP_CFG_RD     8'h2B
`define FSLC_OP_WRITE_ENABLE_CMD       8'h06

`define FSLC_BITS_OPCODE   7'h08
`define FSLC_BITS_ADDR3    7'h20
`define FSLC_BITS_ADDR4    7'h28
`define FSLC_BITS_SAT      7'h40
`define FSLC_RD_START_1    7'h09
`define FSLC_RD_START_4    7'h0C

`define FSLC_SECT_COUNT    256
`define FSLC_SECT_LSB      16
`define FSLC_LOCK_RESET    1'b1

`define FSLC_CLK_NS        10
`define FSLC_OP_TIME_NS    1000
`define FSLC_OP_CYCLES     ((`FSLC_OP_TIME_NS + `FSLC_CLK_NS - 1) / `FSLC_CLK_NS)
`define FSLC_TMR_W         16

`endif

// ===== rtl/fslc_pkg.sv
// Types shared by the sector lock command block.
// Assumes the constants header is included by the design files that need it.
package fslc_pkg;

	typedef enum logic [1:0] {
		FSLC_ST_IDLE = 2'b01,
		FSLC_ST_BUSY = 2'b10
	} fslc_state_t;

	typedef enum logic [3:0] {
		FSLC_K_UNLOCK  = 4'b0001,
		FSLC_K_GLOCK   = 4'b0010,
		FSLC_K_GUNLOCK = 4'b0100,
		FSLC_K_PTR     = 4'b1000
	} fslc_kind_t;

endpackage

// ===== rtl/fslc_sector_lock.sv
// Serial command front end for sector locks, pointer region and configuration read.
// Assumes the host drives sck_i only while cs_n_i is low, in clock mode 0 or 3.
`timescale 1ns/1ps
`include "fslc_defs.svh"

module fslc_sector_lock (
	input  wire logic                        mclk_i,
	input  wire logic                        srst_i,
	input  wire logic                        sck_i,
	input  wire logic                        cs_n_i,
	input  wire logic [3:0]                  io_i,
	output logic      [3:0]                  io_o,
	output logic      [3:0]                  io_oe_o,
	input  wire logic                        addr4_i,
	input  wire logic                        qpi_i,
	input  wire logic                        scheme_sel_i,
	input  wire logic                        nonvolatile_lock_bit_i,
	input  wire logic [15:0]                 prot_cfg_i,
	input  wire logic                        suspend_i,
	input  wire logic                        prog_fail_i,
	input  wire logic                        erase_fail_i,
	input  wire logic                        err_clear_i,
	output logic                             busy_flag_o,
	output logic                             write_enable_latch_o,
	output logic                             prog_error_o,
	output logic                             erase_error_o,
	output logic [`FSLC_SECT_COUNT-1:0]      sector_lock_bit_o,
	output logic [31:0]                      pointer_region_o,
	output logic                             pointer_update_o
);

	// Link side: everything below runs on the serial clock.
	logic        start_q;
	logic [6:0]  cnt_q;
	logic [6:0]  cnt_d;
	logic [39:0] sreg_q;
	logic [39:0] sreg_d;
	logic [7:0]  op_q;
	logic        qpi_s1_q;
	logic        qpi_s2_q;
	logic [15:0] cfg_s1_q;
	logic [15:0] cfg_s2_q;
	logic [3:0]  rpos_q;
	logic [3:0]  dq_q;
	logic [3:0]  oe_q;
	logic [6:0]  step;
	logic [6:0]  rd_start;
	logic        rd_active;

	// Frame start marker; set while select is high so the first edge restarts the count.
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			start_q <= 1'b1;
		end else begin
			start_q <= 1'b0;
		end
	end

	// Mode bits cross into the link clock; they are expected to stay still between frames.
	always_ff @(posedge sck_i) begin
		qpi_s1_q <= qpi_i;
		qpi_s2_q <= qpi_s1_q;
		cfg_s1_q <= prot_cfg_i;
		cfg_s2_q <= cfg_s1_q;
	end

	assign step = qpi_s2_q ? 7'h04 : 7'h01;

	always_comb begin
		if (start_q) begin
			cnt_d = step;
		end else if (cnt_q < `FSLC_BITS_SAT) begin
			cnt_d = cnt_q + step;
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_comb begin
		if (qpi_s2_q) begin
			sreg_d = start_q ? {36'h0_0000_0000, io_i} : {sreg_q[35:0], io_i};
		end else begin
			sreg_d = start_q ? {39'h00_0000_0000, io_i[0]} : {sreg_q[38:0], io_i[0]};
		end
	end

	// The count and shift register are left untouched after the frame, so the core
	// side can read them once it has seen select rise and the serial clock stopped.
	always_ff @(posedge sck_i) begin
		cnt_q  <= cnt_d;
		sreg_q <= sreg_d;
		if (cnt_d == `FSLC_BITS_OPCODE) begin
			op_q <= sreg_d[7:0];
		end
	end

	assign rd_start  = qpi_s2_q ? `FSLC_RD_START_4 : `FSLC_RD_START_1;
	assign rd_active = (op_q == `FSLC_OP_CFG_RD) && (cnt_q >= rd_start);

	// Read data leaves on falling edges; the 4-bit position wraps so the word repeats.
	always_ff @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			oe_q   <= 4'h0;
			dq_q   <= 4'h0;
			rpos_q <= 4'h0;
		end else if (rd_active) begin
			if (qpi_s2_q) begin
				oe_q <= 4'hF;
				dq_q <= cfg_s2_q[rpos_q +: 4];
			end else begin
				oe_q <= 4'h2;
				dq_q <= {2'b00, cfg_s2_q[rpos_q], 1'b0};
			end
			rpos_q <= rpos_q + step[3:0];
		end else begin
			oe_q   <= 4'h0;
			rpos_q <= 4'h0;
		end
	end

	assign io_o    = dq_q;
	assign io_oe_o = oe_q;

	// Core side.
	logic                  cs_s1_q;
	logic                  cs_s2_q;
	logic                  cs_s3_q;
	logic                  cs_rise;
	fslc_pkg::fslc_state_t state_q;
	fslc_pkg::fslc_kind_t  kind_q;
	logic [`FSLC_TMR_W-1:0] tmr_q;
	logic [31:0]           addr_q;
	logic                  wel_q;
	logic                  perr_q;
	logic                  eerr_q;
	logic [31:0]           ptr_q;
	logic                  ptr_upd_q;
	logic                  idle;
	logic                  done;
	logic                  long_addr;
	logic [6:0]            addr_bits;
	logic [31:0]           frame_addr;
	logic                  hit_unlock;
	logic                  hit_glock;
	logic                  hit_gunlock;
	logic                  hit_ptr;
	logic                  hit_write_enable_cmd;
	logic                  ptr_blocked;
	logic                  go;
	logic [7:0]            sect_idx;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n_i;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
		end
	end

	assign cs_rise = cs_s2_q & ~cs_s3_q;
	assign idle    = (state_q == fslc_pkg::FSLC_ST_IDLE);
	assign done    = (state_q == fslc_pkg::FSLC_ST_BUSY) && (tmr_q == '0);
	assign go      = cs_rise && idle;

	assign long_addr  = (op_q == `FSLC_OP_UNLOCK4) || (op_q == `FSLC_OP_PTR4) || addr4_i;
	assign addr_bits  = long_addr ? `FSLC_BITS_ADDR4 : `FSLC_BITS_ADDR3;
	assign frame_addr = long_addr ? sreg_q[31:0] : {8'h00, sreg_q[23:0]};

	// Each command counts only if select rose exactly after its last bit.
	assign hit_unlock  = ((op_q == `FSLC_OP_UNLOCK) || (op_q == `FSLC_OP_UNLOCK4))
	                     && (cnt_q == addr_bits) && scheme_sel_i;
	assign hit_glock   = (op_q == `FSLC_OP_GLOCK) && (cnt_q == `FSLC_BITS_OPCODE)
	                     && scheme_sel_i;
	assign hit_gunlock = (op_q == `FSLC_OP_GUNLOCK) && (cnt_q == `FSLC_BITS_OPCODE)
	                     && scheme_sel_i;
	assign hit_write_enable_cmd    = (op_q == `FSLC_OP_WRITE_ENABLE_CMD) && (cnt_q == `FSLC_BITS_OPCODE);
	assign ptr_blocked = suspend_i || !nonvolatile_lock_bit_i || !prot_cfg_i[1]
	                     || (!prot_cfg_i[2] && !nonvolatile_lock_bit_i);
	assign hit_ptr     = ((op_q == `FSLC_OP_PTR) || (op_q == `FSLC_OP_PTR4))
	                     && (cnt_q == addr_bits) && !ptr_blocked && wel_q;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_q <= fslc_pkg::FSLC_ST_IDLE;
			kind_q  <= fslc_pkg::FSLC_K_UNLOCK;
			tmr_q   <= '0;
			addr_q  <= 32'h0000_0000;
		end else begin
			case (state_q)
				fslc_pkg::FSLC_ST_IDLE: begin
					if (go && (hit_unlock || hit_glock || hit_gunlock || hit_ptr)) begin
						state_q <= fslc_pkg::FSLC_ST_BUSY;
						tmr_q   <= `FSLC_TMR_W'(`FSLC_OP_CYCLES - 1);
						addr_q  <= frame_addr;
						if (hit_unlock) begin
							kind_q <= fslc_pkg::FSLC_K_UNLOCK;
						end else if (hit_glock) begin
							kind_q <= fslc_pkg::FSLC_K_GLOCK;
						end else if (hit_gunlock) begin
							kind_q <= fslc_pkg::FSLC_K_GUNLOCK;
						end else begin
							kind_q <= fslc_pkg::FSLC_K_PTR;
						end
					end
				end
				fslc_pkg::FSLC_ST_BUSY: begin
					if (tmr_q == '0) begin
						state_q <= fslc_pkg::FSLC_ST_IDLE;
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				default: begin
					state_q <= fslc_pkg::FSLC_ST_IDLE;
				end
			endcase
		end
	end

	// The latch is set by a decoded enable and cleared when the pointer operation ends.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wel_q <= 1'b0;
		end else if (go && hit_write_enable_cmd) begin
			wel_q <= 1'b1;
		end else if (done && (kind_q == fslc_pkg::FSLC_K_PTR)) begin
			wel_q <= 1'b0;
		end
	end

	// Error flags are sticky; a failure landing with the clear still sets the flag.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			perr_q    <= 1'b0;
			eerr_q    <= 1'b0;
			ptr_q     <= 32'h0000_0000;
			ptr_upd_q <= 1'b0;
		end else begin
			ptr_upd_q <= 1'b0;
			if (done && (kind_q == fslc_pkg::FSLC_K_PTR) && prog_fail_i) begin
				perr_q <= 1'b1;
			end else if (err_clear_i) begin
				perr_q <= 1'b0;
			end
			if (done && (kind_q == fslc_pkg::FSLC_K_PTR) && erase_fail_i) begin
				eerr_q <= 1'b1;
			end else if (err_clear_i) begin
				eerr_q <= 1'b0;
			end
			if (done && (kind_q == fslc_pkg::FSLC_K_PTR) && !prog_fail_i && !erase_fail_i) begin
				ptr_q     <= addr_q;
				ptr_upd_q <= 1'b1;
			end
		end
	end

	assign sect_idx = addr_q[`FSLC_SECT_LSB +: 8];

	// One volatile bit per sector; zero protects, one unprotects. Updates land at completion.
	genvar g;
	generate
		for (g = 0; g < `FSLC_SECT_COUNT; g++) begin : gen_lock
			logic lock_q;
			always_ff @(posedge mclk_i) begin
				if (srst_i) begin
					lock_q <= `FSLC_LOCK_RESET;
				end else if (done && (kind_q == fslc_pkg::FSLC_K_GLOCK)) begin
					lock_q <= 1'b0;
				end else if (done && (kind_q == fslc_pkg::FSLC_K_GUNLOCK)) begin
					lock_q <= 1'b1;
				end else if (done && (kind_q == fslc_pkg::FSLC_K_UNLOCK)
				             && (sect_idx == 8'(g))) begin
					lock_q <= 1'b1;
				end
			end
			assign sector_lock_bit_o[g] = lock_q;
		end
	endgenerate

	assign busy_flag_o          = !idle;
	assign write_enable_latch_o = wel_q;
	assign prog_error_o         = perr_q;
	assign erase_error_o        = eerr_q;
	assign pointer_region_o     = ptr_q;
	assign pointer_update_o     = ptr_upd_q;

endmodule

// ===== sim/fslc_sector_lock_props.sv
// Port checker for the sector lock command block.
// Assumes control inputs stay still while an operation runs.
`timescale 1ns/1ps
`include "fslc_defs.svh"
module fslc_sector_lock_props (
	input wire logic                        mclk_i,
	input wire logic                        srst_i,
	input wire logic                        cs_n_i,
	input wire logic [3:0]                  io_oe_o,
	input wire logic                        scheme_sel_i,
	input wire logic                        nonvolatile_lock_bit_i,
	input wire logic [15:0]                 prot_cfg_i,
	input wire logic                        suspend_i,
	input wire logic                        busy_flag_o,
	input wire logic                        write_enable_latch_o,
	input wire logic                        prog_error_o,
	input wire logic                        erase_error_o,
	input wire logic [`FSLC_SECT_COUNT-1:0] sector_lock_bit_o,
	input wire logic                        pointer_update_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// Counts busy cycles so the full operation length can be judged at its end.
	logic [7:0] cnt_q;
	always_ff @(posedge mclk_i) cnt_q <= busy_flag_o ? cnt_q + 8'h01 : 8'h00;
	sequence s_done;
		$fell(busy_flag_o);
	endsequence
	property p_busy_len; s_done |-> cnt_q == 8'h64; endproperty
	property p_start; $rose(busy_flag_o) |-> cs_n_i && $past(cs_n_i, 2); endproperty
	property p_wel_clr;
		pointer_update_o |-> !write_enable_latch_o && $past(write_enable_latch_o);
	endproperty
	property p_ptr_done; pointer_update_o |-> s_done; endproperty
	property p_ptr_gate; pointer_update_o |-> !suspend_i && nonvolatile_lock_bit_i && prot_cfg_i[1]; endproperty
	property p_lock_hold; !$stable(sector_lock_bit_o) |-> s_done; endproperty
	property p_scheme; !scheme_sel_i |-> $stable(sector_lock_bit_o); endproperty
	property p_err; $rose(prog_error_o) || $rose(erase_error_o) |-> s_done; endproperty
	property p_oe_off; cs_n_i |-> io_oe_o == 4'h0; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	a_start: assert property (p_start) else $error("busy without select rise");
	a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");
	a_ptr_done: assert property (p_ptr_done) else $error("pointer off completion");
	a_ptr_gate: assert property (p_ptr_gate) else $error("pointer not gated");
	a_lock_hold: assert property (p_lock_hold) else $error("lock changed early");
	a_scheme: assert property (p_scheme) else $error("lock changed, scheme off");
	a_err: assert property (p_err) else $error("error flag off completion");
	a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
endmodule

// ===== sim/fslc_host_model.sv
// Host side of the serial link: frames commands and gathers read data.
// Assumes the bench resolves the data lines from the block's output enables.
`timescale 1ns/1ps
module fslc_host_model (
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      io_o,
	input  wire logic [3:0] io_i
);
	// Select starts low and rises once, so the link's asynchronous restart sees a real edge.
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b0;
		io_o = 4'h0;
		#1 cs_n_o = 1'b1;
	end
	// Sends n bits of v from bit 39 down, then, when nrd is non-zero, one dummy and nrd read cycles.
	task automatic frame(input logic [39:0] v, input int n, input logic q, input int nrd,
		output logic [31:0] rd);
		rd = 32'h0000_0000;
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i += (q ? 4 : 1)) begin
			io_o = q ? v[39-i -: 4] : {~io_o[3:1], v[39-i]};
			#32 sck_o = 1'b1;
			#32 sck_o = 1'b0;
		end
		for (int k = 0; k < (nrd > 0 ? nrd + 1 : 0); k++) begin
			// Idle lines keep toggling so a stale value can never be mistaken for data.
			io_o = ~io_o;
			#32 sck_o = 1'b1;
			if (k > 0 && q) rd[4*(k-1) +: 4] = io_i;
			else if (k > 0) rd[k-1] = io_i[1];
			#32 sck_o = 1'b0;
		end
		#32 cs_n_o = 1'b1;
		// Select stays high long enough for the core to see the rise before the next frame.
		#64;
	endtask
endmodule

// ===== sim/fslc_sector_lock_test.sv
// Self-checking bench for the sector lock command block.
// Assumes the host model owns the link and the bench owns the control pins.
`timescale 1ns/1ps
`include "fslc_defs.svh"
module fslc_sector_lock_test;
	logic mclk_i = 1'b0, srst_i = 1'b1, addr4_i = 1'b0, qpi_i = 1'b0, scheme_sel_i = 1'b1;
	logic nonvolatile_lock_bit_i = 1'b1, suspend_i = 1'b0, pf = 1'b0, ef = 1'b0, err_clear_i = 1'b0;
	logic [15:0] prot_cfg_i = 16'hA5C3;
	logic [31:0] rd, ptr;
	logic sck, cs_n, busy, write_enable_latch, perr, eerr, pupd;
	logic [3:0] io_h, io_o, io_oe, io_w;
	logic [`FSLC_SECT_COUNT-1:0] locks;
	int n_mismatch = 0, cmp_count = 0;
	assign io_w = (io_oe & io_o) | (~io_oe & io_h);
	always #5 mclk_i = ~mclk_i;
	fslc_host_model h (.sck_o(sck), .cs_n_o(cs_n), .io_o(io_h), .io_i(io_w));
	fslc_sector_lock uut (.mclk_i, .srst_i, .sck_i(sck), .cs_n_i(cs_n), .io_i(io_w),
		.io_o(io_o), .io_oe_o(io_oe), .addr4_i, .qpi_i, .scheme_sel_i, .nonvolatile_lock_bit_i,
		.prot_cfg_i, .suspend_i, .prog_fail_i(pf), .erase_fail_i(ef), .err_clear_i,
		.busy_flag_o(busy), .write_enable_latch_o(write_enable_latch), .prog_error_o(perr),
		.erase_error_o(eerr), .sector_lock_bit_o(locks), .pointer_region_o(ptr),
		.pointer_update_o(pupd));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Sends one frame, checks whether it started an operation and waits it out.
	task automatic cmd(input logic [39:0] v, input int n, input logic b);
		h.frame(v, n, qpi_i, 0, rd);
		repeat (6) @(posedge mclk_i);
		#1 chk("busy", {31'h0, b}, {31'h0, busy});
		for (int t = 0; t < 200 && busy === 1'b1; t++) begin
			@(posedge mclk_i);
			#1;
		end
		if (busy !== 1'b0) begin
			n_mismatch++;
			conclude();
		end
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge mclk_i);
		#1 srst_i = 1'b0;
		repeat (4) @(posedge mclk_i);
		#1 chk("all unlocked", 32'h1, &locks);
		cmd({8'h7E, 32'h0}, 8, 1);
		chk("any unlocked", 32'h0, |locks);
		cmd({8'h98, 32'h0}, 9, 0);
		chk("any unlocked", 32'h0, |locks);
		cmd({8'h98, 32'h0}, 8, 1);
		chk("all unlocked", 32'h1, &locks);
		cmd({8'h7E, 32'h0}, 8, 1);
		$display("global commands done");
		cmd({8'h39, 24'hA5_0000, 8'h0}, 32, 1);
		chk("sector a5", 32'h1, locks[8'hA5]);
		chk("sector a4", 32'h0, locks[8'hA4]);
		cmd({8'hE2, 32'h005A_0000}, 40, 1);
		chk("sector 5a", 32'h1, locks[8'h5A]);
		addr4_i = 1'b1;
		cmd({8'h39, 24'h01_0000, 8'h0}, 32, 0);
		cmd({8'h39, 32'h003C_0000}, 40, 1);
		chk("sector 3c", 32'h1, locks[8'h3C]);
		chk("sector 01", 32'h0, locks[8'h01]);
		addr4_i = 1'b0;
		qpi_i = 1'b1;
		h.frame(40'h0, 8, 1'b1, 0, rd);
		cmd({8'h39, 24'h11_0000, 8'h0}, 32, 1);
		chk("sector 11", 32'h1, locks[8'h11]);
		qpi_i = 1'b0;
		h.frame(40'h0, 8, 1'b0, 0, rd);
		scheme_sel_i = 1'b0;
		cmd({8'h7E, 32'h0}, 8, 0);
		chk("sector 11", 32'h1, locks[8'h11]);
		scheme_sel_i = 1'b1;
		$display("sector commands done");
		cmd({8'hFB, 24'h12_3400, 8'h0}, 32, 0);
		cmd({8'h06, 32'h0}, 8, 0);
		for (int c = 0; c < 4; c++) begin
			suspend_i = (c == 0);
			nonvolatile_lock_bit_i = (c != 1);
			prot_cfg_i[1] = (c != 2);
			cmd({8'hFB, 24'h12_3400, 8'h0}, c == 3 ? 33 : 32, 0);
			chk("pointer", 32'h0, ptr);
			chk("latch", 32'h1, write_enable_latch);
		end
		cmd({8'hFB, 24'h12_3400, 8'h0}, 32, 1);
		chk("pointer", 32'h0012_3400, ptr);
		chk("latch", 32'h0, write_enable_latch);
		cmd({8'h06, 32'h0}, 8, 0);
		cmd({8'hE3, 32'h0123_4500}, 40, 1);
		chk("pointer", 32'h0123_4500, ptr);
		for (int f = 0; f < 2; f++) begin
			pf = (f == 0);
			ef = (f == 1);
			cmd({8'h06, 32'h0}, 8, 0);
			cmd({8'hE3, 32'h0000_0100}, 40, 1);
			chk("errors", f ? 32'h1 : 32'h2, {perr, eerr});
			chk("pointer", 32'h0123_4500, ptr);
			err_clear_i = 1'b1;
			@(posedge mclk_i);
			#1 err_clear_i = 1'b0;
		end
		pf = 1'b0;
		ef = 1'b0;
		addr4_i = 1'b1;
		cmd({8'h06, 32'h0}, 8, 0);
		cmd({8'hFB, 32'h0456_7800}, 40, 1);
		chk("pointer", 32'h0456_7800, ptr);
		chk("latch", 32'h0, write_enable_latch);
		addr4_i = 1'b0;
		$display("pointer commands done");
		h.frame({8'h2B, 32'h0}, 8, 1'b0, 32, rd);
		chk("config read", {prot_cfg_i, prot_cfg_i}, rd);
		qpi_i = 1'b1;
		h.frame(40'h0, 8, 1'b1, 0, rd);
		h.frame({8'h2B, 32'h0}, 8, 1'b1, 8, rd);
		chk("four-wire read", {prot_cfg_i, prot_cfg_i}, rd);
		qpi_i = 1'b0;
		$display("config read done");
		conclude();
	end
endmodule
bind fslc_sector_lock fslc_sector_lock_props chk (.mclk_i, .srst_i, .cs_n_i, .io_oe_o,
	.scheme_sel_i, .nonvolatile_lock_bit_i, .prot_cfg_i, .suspend_i, .busy_flag_o, .write_enable_latch_o,
	.prog_error_o, .erase_error_o, .sector_lock_bit_o, .pointer_update_o);
